// [bench/adc_output_formatter_bench.sv]
// self-checking bench for the sample output formatter
// assumes the capture model watches the forwarded clock and buses
module adc_output_formatter_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic               i_mclk, i_sys_rst, i_wr, i_rd, i_smp_vld;
	logic [7:0]         i_addr;
	logic [15:0]        i_wdata, o_rdata;
	fmt_pkg::sample_s   i_smp, a, b;
	fmt_pkg::out_word_s o_bus;
	logic               nsplit, cm_pin, trig, phase, o_clk, o_swing, o_cm, cap_trig;
	int                 mismatches, checks, words, cap_count, seed;
	bit                 tw, st;
	int                 nd_seq[10] = '{0, 0, 1, 1, 0, 1, 0, 1, 1, 1};

	adc_output_formatter adc_output_formatter_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_smp_vld(i_smp_vld), .i_smp(i_smp),
		.i_no_split_select_pin(nsplit), .i_common_mode_select_pin(cm_pin),
		.i_outclk_realign_input(trig), .i_ddr_phase_pin(phase), .o_bus(o_bus),
		.o_output_data_clock(o_clk), .o_output_swing_select(o_swing),
		.o_common_mode_high(o_cm)
	);
	capture_model capture_model_inst (
		.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_clk_fwd(o_clk), .i_stamp(st),
		.i_bus(o_bus), .o_count(cap_count), .o_trig(cap_trig)
	);

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	task automatic chk(input string name, input logic [49:0] seen, input logic [49:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(posedge i_mclk);
		i_addr  <= ad;
		i_wdata <= d;
		i_wr    <= 1'b1;
		@(posedge i_mclk);
		i_wr    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] ad, input logic [15:0] exp);
		@(posedge i_mclk);
		i_addr <= ad;
		i_rd   <= 1'b1;
		@(posedge i_mclk);
		i_rd   <= 1'b0;
		@(negedge i_mclk);
		chk("rdata", 50'(o_rdata), 50'(exp));
	endtask : rd

	task automatic put(input fmt_pkg::sample_s s);
		@(posedge i_mclk);
		i_smp_vld <= 1'b1;
		i_smp     <= s;
		@(posedge i_mclk);
		i_smp_vld <= 1'b0;
		repeat (3) @(posedge i_mclk);
		@(negedge i_mclk);
	endtask : put

	function automatic fmt_pkg::sample_s rnd();
		return fmt_pkg::sample_s'(26'($random(seed)));
	endfunction : rnd

	// two's complement flips the msb; stamping replaces the lsb
	function automatic logic [11:0] fmt(input logic [11:0] v, input bit t, input bit s,
		input bit r);
		logic [11:0] x;
		x = t ? {~v[11], v[10:0]} : v;
		if (s) x[0] = r;
		return x;
	endfunction : fmt

	function automatic fmt_pkg::out_word_s pat(input int k, input bit nd);
		fmt_pkg::out_word_s w;
		bit                 h;
		h = nd ? nd_seq[k % 10] != 0 : (k % 5) % 2 == 1;
		w = '0;
		w.q = (nd ? 12'h000 : 12'h008) ^ {12{h}};
		w.i = (nd ? 12'h004 : 12'h010) ^ {12{h}};
		if (!nd) begin
			w.qd = 12'h000 ^ {12{h}};
			w.id = 12'h004 ^ {12{h}};
		end
		w.or_q = h;
		w.or_i = h;
		return w;
	endfunction : pat

	task automatic results();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	initial begin
		repeat (20000) @(posedge i_mclk);
		mismatches++;
		$display("run cut short by watchdog");
		results();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'ha755;
		{i_wr, i_rd, i_smp_vld, i_addr, i_wdata, i_smp} = '0;
		{nsplit, trig, phase, st} = '0;
		cm_pin = 1'b1;
		i_sys_rst = 1'b1;
		repeat (3) @(posedge i_mclk);
		i_sys_rst <= 1'b0;
		// registers, swing bit and common-mode pin
		rd(8'h00, 16'h0000);
		rd(8'h04, 16'h0000);
		wr(8'h30, 16'hffff);
		rd(8'h30, 16'h0000);
		wr(8'h00, 16'h2010);
		rd(8'h00, 16'h2010);
		chk("swing", 50'(o_swing), 50'h1);
		chk("cmode", 50'(o_cm), 50'h1);
		wr(8'h00, 16'h0000);
		rd(8'h00, 16'h0000);
		chk("swing", 50'(o_swing), 50'h0);
		$display("registers done");
		// split data, pairs of samples
		for (int n = 0; n < 4; n++) begin
			a = rnd();
			b = rnd();
			put(a);
			put(b);
			words++;
			chk("split", o_bus, {a.q, a.i, b.q, b.i, a.or_q | b.or_q, a.or_i | b.or_i});
		end
		$display("split data done");
		// split pattern, then with channel i powered down
		wr(8'h04, 16'h0002);
		for (int k = 0; k < 12; k++) begin
			put(rnd());
			put(rnd());
			words++;
			chk("pat5", o_bus, pat(k, 1'b0));
		end
		wr(8'h04, 16'h0000);
		wr(8'h04, 16'h0006);
		for (int k = 0; k < 5; k++) begin
			put(rnd());
			put(rnd());
			words++;
			chk("pd_q", 50'(o_bus.q), 50'(pat(k, 1'b0).q));
			chk("pd_i", 50'({o_bus.id, o_bus.i}), 50'h0);
		end
		wr(8'h04, 16'h0000);
		$display("split pattern done");
		// unsplit pattern
		nsplit <= 1'b1;
		repeat (4) @(posedge i_mclk);
		wr(8'h04, 16'h0002);
		for (int k = 0; k < 20; k++) begin
			put(rnd());
			words++;
			chk("pat10", o_bus, pat(k, 1'b1));
		end
		wr(8'h04, 16'h0000);
		$display("unsplit pattern done");
		// unsplit data; phase and single-rate requests must be ignored
		wr(8'h04, 16'h0021);
		for (int n = 0; n < 8; n++) begin
			a = rnd();
			tw = 1'($random(seed));
			st = 1'($random(seed));
			wr(8'h00, {1'b0, 1'b1, 9'h0, tw, st, 3'h0});
			trig <= 1'($random(seed));
			repeat (4) @(posedge i_mclk);
			put(a);
			words++;
			chk("unsplit", o_bus, {24'h0, fmt(a.q, tw, st, trig), fmt(a.i, tw, st, trig),
				a.or_q, a.or_i});
			chk("cap_trig", 50'(cap_trig), 50'(st & trig));
		end
		chk("words", 50'(cap_count), 50'(words));
		$display("unsplit data done");
		// split single rate: launch edge from cfg bit 2, clock inverts a cycle later
		nsplit <= 1'b0;
		repeat (4) @(posedge i_mclk);
		wr(8'h04, 16'h0021);
		for (int r = 0; r < 2; r++) begin
			wr(8'h00, 16'(r << 2));
			put(rnd());
			put(rnd());
			chk("sdr_clk", 50'(o_clk), 50'(r == 0));
		end
		wr(8'h04, 16'h0000);
		$display("single rate done");
		results();
	end
endmodule : adc_output_formatter_bench

// [bench/capture_model.sv]
// capture side model: counts every forwarded clock edge and latches the trigger stamp from q lsb
// assumes zero-phase dual-rate forwarding, clock and buses registered on i_mclk
module capture_model (
	// clock and reset
	input  wire logic               i_mclk,
	input  wire logic               i_sys_rst,
	// link from the formatter
	input  wire logic               i_clk_fwd,
	input  wire logic               i_stamp,
	input  wire fmt_pkg::out_word_s i_bus,
	// captured view
	output int                      o_count,
	output logic                    o_trig
);
	logic clk_d;

	always @(posedge i_mclk) begin
		if (i_sys_rst) begin
			clk_d   <= 1'b0;
			o_count <= 0;
			o_trig  <= 1'b0;
		end else begin
			clk_d <= i_clk_fwd;
			if (clk_d != i_clk_fwd) begin
				o_count <= o_count + 1;
				o_trig  <= i_stamp & i_bus.q[0];
			end
		end
	end
endmodule : capture_model

// [logic/adc_output_formatter.sv]
// output formatter: formats samples, splits them onto buses, drives patterns
// and forwards the output data clock
// assumes converter samples arrive on i_mclk with i_smp_vld; pins are asynchronous
//
// Decided for this implementation: the register addresses and the plain strobed port.
module adc_output_formatter (
	// clock and reset
	input  wire logic              i_mclk,
	input  wire logic              i_sys_rst,
	// register port
	input  wire logic [7:0]        i_addr,
	input  wire logic [15:0]       i_wdata,
	input  wire logic              i_wr,
	input  wire logic              i_rd,
	output logic      [15:0]       o_rdata,
	// converted samples
	input  wire logic              i_smp_vld,
	input  wire fmt_pkg::sample_s  i_smp,
	// pins
	input  wire logic              i_no_split_select_pin,
	input  wire logic              i_common_mode_select_pin,
	input  wire logic              i_outclk_realign_input,
	input  wire logic              i_ddr_phase_pin,
	// output buses and clock
	output fmt_pkg::out_word_s     o_bus,
	output logic                   o_output_data_clock,
	output logic                   o_output_swing_select,
	output logic                   o_common_mode_high
);
	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [3:0] pins_sync;
	logic       no_split;
	logic       cm_high;
	logic       trig_sync;
	logic       phase_pin;

	bit_sync2 #(.W(4)) u_pins (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_d       ({i_no_split_select_pin, i_common_mode_select_pin,
			i_outclk_realign_input, i_ddr_phase_pin}),
		.o_q       (pins_sync)
	);

	assign no_split  = pins_sync[3];
	assign cm_high   = pins_sync[2];
	assign trig_sync = pins_sync[1];
	assign phase_pin = pins_sync[0];

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] cfg_reg;
	logic [15:0] cfg_next;
	logic [15:0] outctl_reg;
	logic [15:0] outctl_next;
	logic [15:0] rdata_reg;
	logic [15:0] rdata_next;
	logic [3:0]  pat_index;

	always_comb begin
		cfg_next    = cfg_reg;
		outctl_next = outctl_reg;
		rdata_next  = 16'h0000;
		if (i_wr) begin
			unique case (i_addr)
				fmt_pkg::ADDR_CFG:    cfg_next    = i_wdata;
				fmt_pkg::ADDR_OUTCTL: outctl_next = {10'h000, i_wdata[5:0]};
				default:              ;
			endcase
		end
		if (i_rd) begin
			unique case (i_addr)
				fmt_pkg::ADDR_CFG:    rdata_next = cfg_reg;
				fmt_pkg::ADDR_OUTCTL: rdata_next = outctl_reg;
				fmt_pkg::ADDR_STATUS: rdata_next = {8'h00, pat_index, 1'b0,
					trig_sync, cm_high, no_split};
				default:              rdata_next = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			cfg_reg    <= fmt_pkg::CFG_RST;
			outctl_reg <= fmt_pkg::OUTCTL_RST;
			rdata_reg  <= 16'h0000;
		end else begin
			cfg_reg    <= cfg_next;
			outctl_reg <= outctl_next;
			rdata_reg  <= rdata_next;
		end
	end

	assign o_rdata               = rdata_reg;
	assign o_output_swing_select = cfg_reg[fmt_pkg::CFG_SWING];
	assign o_common_mode_high    = cm_high;

	////////////////////////////////////////////////////////////////////////////
	// mode decode
	logic extended_control_mode;
	logic test_on;
	logic pd_i;
	logic pd_q;
	logic demux;
	fmt_pkg::clk_mode_e clk_mode;

	assign extended_control_mode     = outctl_reg[fmt_pkg::OUT_ECM];
	assign test_on = outctl_reg[fmt_pkg::OUT_TEST];
	assign pd_i    = outctl_reg[fmt_pkg::OUT_PD_I];
	assign pd_q    = outctl_reg[fmt_pkg::OUT_PD_Q];
	assign demux   = !no_split;

	always_comb begin
		if (no_split) begin
			clk_mode = fmt_pkg::CLK_DDR0;
		end else if (extended_control_mode && outctl_reg[fmt_pkg::OUT_SDR]) begin
			clk_mode = fmt_pkg::CLK_SDR;
		end else if (extended_control_mode ? cfg_reg[fmt_pkg::CFG_DPS] : phase_pin) begin
			clk_mode = fmt_pkg::CLK_DDR90;
		end else begin
			clk_mode = fmt_pkg::CLK_DDR0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// formatting and splitting
	function automatic logic [11:0] fmt_word(input logic [11:0] d, input logic twos,
		input logic stamp, input logic trig);
		logic [11:0] r;
		r = twos ? {~d[11], d[10:0]} : d;
		if (stamp) begin
			r[0] = trig;
		end
		return r;
	endfunction : fmt_word

	fmt_pkg::sample_s  cur;
	fmt_pkg::sample_s  hold_reg;
	fmt_pkg::sample_s  hold_next;
	fmt_pkg::out_word_s bus_reg;
	fmt_pkg::out_word_s bus_next;
	logic              phase_reg;
	logic              phase_next;
	logic              wstr;
	logic              pat_high;

	always_comb begin
		cur.q    = fmt_word(i_smp.q, cfg_reg[fmt_pkg::CFG_TWOS],
			cfg_reg[fmt_pkg::CFG_STAMP], trig_sync);
		cur.i    = fmt_word(i_smp.i, cfg_reg[fmt_pkg::CFG_TWOS],
			cfg_reg[fmt_pkg::CFG_STAMP], trig_sync);
		cur.or_q = i_smp.or_q;
		cur.or_i = i_smp.or_i;
	end

	pattern_gen u_pat (
		.i_mclk    (i_mclk),
		.i_sys_rst (i_sys_rst),
		.i_clear   (!test_on),
		.i_step    (wstr && test_on),
		.i_demux   (demux),
		.o_high    (pat_high),
		.o_index   (pat_index)
	);

	always_comb begin
		phase_next = phase_reg;
		hold_next  = hold_reg;
		bus_next   = bus_reg;
		wstr       = 1'b0;
		if (i_smp_vld) begin
			if (demux && !phase_reg) begin
				hold_next  = cur;
				phase_next = 1'b1;
			end else begin
				wstr       = 1'b1;
				phase_next = 1'b0;
			end
		end
		if (wstr) begin
			if (test_on) begin
				if (demux) begin
					bus_next.qd = pat_high ? ~fmt_pkg::PAT_QD : fmt_pkg::PAT_QD;
					bus_next.id = pat_high ? ~fmt_pkg::PAT_ID : fmt_pkg::PAT_ID;
					bus_next.q  = pat_high ? ~fmt_pkg::PAT_Q : fmt_pkg::PAT_Q;
					bus_next.i  = pat_high ? ~fmt_pkg::PAT_I : fmt_pkg::PAT_I;
				end else begin
					bus_next.qd = 12'h000;
					bus_next.id = 12'h000;
					bus_next.q  = pat_high ? ~fmt_pkg::PAT_QD : fmt_pkg::PAT_QD;
					bus_next.i  = pat_high ? ~fmt_pkg::PAT_ID : fmt_pkg::PAT_ID;
				end
				bus_next.or_q = pat_high;
				bus_next.or_i = pat_high;
			end else if (demux) begin
				bus_next.qd   = hold_reg.q;
				bus_next.id   = hold_reg.i;
				bus_next.q    = cur.q;
				bus_next.i    = cur.i;
				bus_next.or_q = hold_reg.or_q | cur.or_q;
				bus_next.or_i = hold_reg.or_i | cur.or_i;
			end else begin
				bus_next.qd   = 12'h000;
				bus_next.id   = 12'h000;
				bus_next.q    = cur.q;
				bus_next.i    = cur.i;
				bus_next.or_q = cur.or_q;
				bus_next.or_i = cur.or_i;
			end
		end
		if (pd_i) begin
			bus_next.id   = 12'h000;
			bus_next.i    = 12'h000;
			bus_next.or_i = 1'b0;
		end
		if (pd_q) begin
			bus_next.qd   = 12'h000;
			bus_next.q    = 12'h000;
			bus_next.or_q = 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			hold_reg  <= '0;
			bus_reg   <= '0;
			phase_reg <= 1'b0;
		end else begin
			hold_reg  <= hold_next;
			bus_reg   <= bus_next;
			phase_reg <= phase_next;
		end
	end

	assign o_bus = bus_reg;

	////////////////////////////////////////////////////////////////////////////
	// output data clock
	logic clk_reg;
	logic clk_next;
	logic mid_reg;
	logic mid_next;

	always_comb begin
		clk_next = clk_reg;
		mid_next = 1'b0;
		if (wstr) begin
			mid_next = 1'b1;
			unique case (clk_mode)
				fmt_pkg::CLK_DDR0:  clk_next = ~clk_reg;
				fmt_pkg::CLK_DDR90: clk_next = clk_reg;
				fmt_pkg::CLK_SDR:   clk_next = cfg_reg[fmt_pkg::CFG_SDR_RISE];
			endcase
		end else if (mid_reg) begin
			unique case (clk_mode)
				fmt_pkg::CLK_DDR0:  clk_next = clk_reg;
				fmt_pkg::CLK_DDR90: clk_next = ~clk_reg;
				fmt_pkg::CLK_SDR:   clk_next = ~clk_reg;
			endcase
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			clk_reg <= 1'b0;
			mid_reg <= 1'b0;
		end else begin
			clk_reg <= clk_next;
			mid_reg <= mid_next;
		end
	end

	assign o_output_data_clock = clk_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	property p_swing;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_wr && i_addr == fmt_pkg::ADDR_CFG) |=> o_output_swing_select == $past(i_wdata[13]);
	endproperty
	a_swing: assert property (p_swing) else $error("swing not taken from write");

	property p_twos;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wstr && !test_on && !demux && !pd_q && cfg_reg[fmt_pkg::CFG_TWOS])
			|=> o_bus.q[11] == !$past(i_smp.q[11]);
	endproperty
	a_twos: assert property (p_twos) else $error("two's complement msb wrong");

	property p_pin_only;
		@(posedge i_mclk) disable iff (i_sys_rst)
		$changed(demux) |-> $past(i_no_split_select_pin, 2) != $past(i_no_split_select_pin, 3);
	endproperty
	a_pin_only: assert property (p_pin_only) else $error("split mode moved without pin");

	property p_nosplit_ddr0;
		@(posedge i_mclk) disable iff (i_sys_rst)
		no_split |-> clk_mode == fmt_pkg::CLK_DDR0;
	endproperty
	a_nosplit_ddr0: assert property (p_nosplit_ddr0) else $error("illegal clock mode");

	property p_pd_pattern;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(test_on && pd_i) |=> (o_bus.i == 12'h000 && o_bus.id == 12'h000 && !o_bus.or_i);
	endproperty
	a_pd_pattern: assert property (p_pd_pattern) else $error("pattern on powered-down i");

	property p_nodemux_word;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wstr && test_on && !demux && !pd_q && !pd_i)
			|=> ((o_bus.q == 12'h000 && o_bus.i == 12'h004 && !o_bus.or_q)
			|| (o_bus.q == 12'hfff && o_bus.i == 12'hffb && o_bus.or_q));
	endproperty
	a_nodemux_word: assert property (p_nodemux_word) else $error("bad no-split pattern");

	property p_stamp;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wstr && !test_on && !demux && !pd_i && cfg_reg[fmt_pkg::CFG_STAMP])
			|=> o_bus.i[0] == $past(trig_sync);
	endproperty
	a_stamp: assert property (p_stamp) else $error("trigger not in lsb");

	property p_ddr0_toggle;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wstr && clk_mode == fmt_pkg::CLK_DDR0) |=> o_output_data_clock != $past(clk_reg);
	endproperty
	a_ddr0_toggle: assert property (p_ddr0_toggle) else $error("clock missed word edge");

	property p_sdr_edge;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(wstr && clk_mode == fmt_pkg::CLK_SDR)
			|=> o_output_data_clock == $past(cfg_reg[2]) ##1 o_output_data_clock != $past(clk_reg);
	endproperty
	a_sdr_edge: assert property (p_sdr_edge) else $error("single rate edge wrong");

	c_demux_test: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
		wstr && test_on && demux);
	c_nodemux_data: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
		wstr && !test_on && !demux);
	c_ddr90: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
		wstr && clk_mode == fmt_pkg::CLK_DDR90);
	c_stamp_hit: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
		wstr && cfg_reg[fmt_pkg::CFG_STAMP] && trig_sync);
endmodule : adc_output_formatter

// [logic/bit_sync2.sv]
// two flip-flop synchroniser for levels arriving from outside the clock domain
// assumes each bit is an independent level
module bit_sync2 #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         i_mclk,
	input  wire logic         i_sys_rst,
	// level in and out
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			meta_reg <= '0;
			q_reg    <= '0;
		end else begin
			meta_reg <= i_d;
			q_reg    <= meta_reg;
		end
	end

	assign o_q = q_reg;
endmodule : bit_sync2

// [logic/fmt_pkg.sv]
// constants, field positions and carrier types of the sample output formatter
// assumes one system clock; pins are synchronised inside the formatter
//
// Summary of operation
// - cfg bit 13 selects output swing
// - offset binary default, bit 4 two's complement
// - no split: full rate, one bus each
// - split: half rate on doubled buses
// - split choice comes only from pin
// - split 1:2 per channel, 1:4 interleaved (OUT_DES is stored but ignored; split is always 1:2)
// - no split: only double rate, zero phase
// - test mode drives patterns on all outputs of powered-up channels, except the delayed buses, which stay zero with no split
// - powered-down channel gets no pattern
// - each port alternates low word, complement
// - split pattern: five words repeating
// - no split pattern: ten words repeating
// - bit 3 puts trigger in lsb
// - trigger has same latency as data
// - trigger may be asynchronous, is synchronised
// - common-mode level chosen by pin
// - double rate phase from bit 14 in extended control mode, else from pin
// - single rate edge from bit 2
// - word order delayed q, delayed i, q, i
// - double rate clock at half word rate
package fmt_pkg;
	localparam int          SAMPLE_W        = 12;
	localparam logic [7:0]  ADDR_CFG        = 8'h00;
	localparam logic [7:0]  ADDR_OUTCTL     = 8'h04;
	localparam logic [7:0]  ADDR_STATUS     = 8'h08;
	localparam int          CFG_SDR_RISE    = 2;
	localparam int          CFG_STAMP       = 3;
	localparam int          CFG_TWOS        = 4;
	localparam int          CFG_SWING       = 13;
	localparam int          CFG_DPS         = 14;
	localparam int          OUT_ECM         = 0;
	localparam int          OUT_TEST        = 1;
	localparam int          OUT_PD_I        = 2;
	localparam int          OUT_PD_Q        = 3;
	localparam int          OUT_DES         = 4;
	localparam int          OUT_SDR         = 5;
	localparam logic [15:0] CFG_RST         = 16'h0000;
	localparam logic [15:0] OUTCTL_RST      = 16'h0000;
	localparam logic [11:0] PAT_QD          = 12'h000;
	localparam logic [11:0] PAT_ID          = 12'h004;
	localparam logic [11:0] PAT_Q           = 12'h008;
	localparam logic [11:0] PAT_I           = 12'h010;
	localparam logic [3:0]  DEMUX_SEQ_LAST  = 4'h4;
	localparam logic [3:0]  NODEMUX_SEQ_LAST = 4'h9;
	localparam logic [9:0]  DEMUX_SEQ_MASK  = 10'h00a;
	localparam logic [9:0]  NODEMUX_SEQ_MASK = 10'h3ac;

	typedef enum {CLK_DDR0, CLK_DDR90, CLK_SDR} clk_mode_e;

	typedef struct packed {
		logic [11:0] q;
		logic [11:0] i;
		logic        or_q;
		logic        or_i;
	} sample_s;

	typedef struct packed {
		logic [11:0] qd;
		logic [11:0] id;
		logic [11:0] q;
		logic [11:0] i;
		logic        or_q;
		logic        or_i;
	} out_word_s;
endpackage : fmt_pkg

// [logic/pattern_gen.sv]
// test pattern sequencer: tells whether the current word is the complemented one
// assumes i_step pulses once per output word while test mode runs
module pattern_gen (
	// clock and reset
	input  wire logic       i_mclk,
	input  wire logic       i_sys_rst,
	// control
	input  wire logic       i_clear,
	input  wire logic       i_step,
	input  wire logic       i_demux,
	// state
	output logic            o_high,
	output logic      [3:0] o_index
);
	logic [3:0] idx_reg;
	logic [3:0] idx_next;
	logic [3:0] last;

	always_comb begin
		last     = i_demux ? fmt_pkg::DEMUX_SEQ_LAST : fmt_pkg::NODEMUX_SEQ_LAST;
		idx_next = idx_reg;
		if (i_clear) begin
			idx_next = 4'h0;
		end else if (i_step) begin
			idx_next = (idx_reg >= last) ? 4'h0 : idx_reg + 4'h1;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_sys_rst) begin
			idx_reg <= 4'h0;
		end else begin
			idx_reg <= idx_next;
		end
	end

	assign o_high  = i_demux ? fmt_pkg::DEMUX_SEQ_MASK[idx_reg] :
		fmt_pkg::NODEMUX_SEQ_MASK[idx_reg];
	assign o_index = idx_reg;

	////////////////////////////////////////////////////////////////////////////
	property p_demux_wrap;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_step && !i_clear && i_demux && idx_reg == 4'h4) |=> idx_reg == 4'h0;
	endproperty
	a_demux_wrap: assert property (p_demux_wrap) else $error("five word sequence did not wrap");

	property p_nodemux_wrap;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(i_step && !i_clear && !i_demux && idx_reg == 4'h9) |=> idx_reg == 4'h0;
	endproperty
	a_nodemux_wrap: assert property (p_nodemux_wrap) else $error("ten word sequence did not wrap");

	property p_hold_step;
		@(posedge i_mclk) disable iff (i_sys_rst)
		(!i_step && !i_clear) |=> $stable(idx_reg);
	endproperty
	a_hold_step: assert property (p_hold_step) else $error("pattern moved without a word");
endmodule : pattern_gen
